// ===== rtl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CSR     = 8'h3C;
   localparam logic [7:0] OFS_RESULT  = 8'h40;
   localparam logic [7:0] OFS_CLK_SEL = 8'h44;

   // control and status bit positions
   localparam int unsigned CSR_DONE_BIT = 7;
   localparam int unsigned CSR_IRQ_BIT  = 6;
   localparam int unsigned CSR_CONT_BIT = 5;

   // reset values
   localparam logic [7:0] CSR_RESET     = 8'h1F;
   localparam logic [7:0] CLK_SEL_RESET = 8'h00;

   // channel codes
   localparam logic [4:0] CHAN_LAST_PIN = 5'h07;
   localparam logic [4:0] CHAN_UPPER    = 5'h1D;
   localparam logic [4:0] CHAN_LOWER    = 5'h1E;
   localparam logic [4:0] CHAN_OFF      = 5'h1F;

   // conversion timing in converter clocks
   localparam logic [2:0] SAMPLE_LAST = 3'h7;
   localparam logic [2:0] MSB_INDEX   = 3'h7;
   localparam logic [7:0] SAR_FIRST   = 8'h80;

   // ahb transfer type bit that marks an active transfer
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;

   typedef struct packed {
      logic       done;
      logic       irq_en;
      logic       cont;
      logic [4:0] chan;
   } csr_s;

   typedef struct packed {
      logic [2:0] prescale;
      logic       src_bus;
      logic [3:0] unused;
   } clk_sel_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SAMPLE,
      ST_CONVERT
   } conv_state_e;

endpackage

// ===== rtl/adc_ctrl.sv
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int unsigned NUM_PINS = 8
)
(
   // clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic                     hresp,
   output logic [31:0]              hrdata,
   // converter clock source and power state
   input  wire logic                crystal_clock,
   input  wire logic                stop_mode,
   // analog section
   input  wire logic                comparator_in,
   output logic [7:0]               dac_code,
   output logic [4:0]               analog_mux_sel,
   output logic                     analog_power_on,
   output logic                     sample_en,
   // shared port pins
   input  wire logic [NUM_PINS-1:0] port_data,
   input  wire logic [NUM_PINS-1:0] port_dir,
   input  wire logic [NUM_PINS-1:0] pin_in,
   output logic [NUM_PINS-1:0]      pin_out,
   output logic [NUM_PINS-1:0]      pin_oe,
   output logic [NUM_PINS-1:0]      port_read,
   output logic [NUM_PINS-1:0]      analog_switch_en,
   // completion interrupt
   output logic                     done_irq
);

   csr_s        control_status_reg_ff;
   clk_sel_s    clock_select_reg_ff;
   logic [7:0]  conversion_result_ff;
   logic        irq_ff;

   logic        dph_valid_ff;
   logic        dph_write_ff;
   logic [7:0]  dph_addr_ff;

   logic        xtal_meta_ff;
   logic        xtal_sync_ff;
   logic        xtal_prev_ff;
   logic        comp_meta_ff;
   logic        comp_sync_ff;
   logic [NUM_PINS-1:0] pin_meta_ff;
   logic [NUM_PINS-1:0] pin_sync_ff;

   logic [3:0]  div_cnt_ff;
   conv_state_e state_ff;
   logic        start_pend_ff;
   logic [2:0]  samp_cnt_ff;
   logic [2:0]  bit_idx_ff;
   logic [7:0]  sar_ff;

   logic        addr_phase;
   logic        csr_wr;
   logic        clk_wr;
   logic        result_rd;
   logic        src_tick;
   logic [3:0]  div_last;
   logic        adc_tick;
   logic        powered;
   logic        conv_done;
   logic [7:0]  sar_final;

   // bus interface: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign addr_phase = hsel & hready & htrans[HTRANS_ACTIVE_BIT];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_valid_ff <= 1'b0;
         dph_write_ff <= 1'b0;
         dph_addr_ff  <= 8'h00;
      end
      else if (hready)
      begin
         dph_valid_ff <= addr_phase;
         dph_write_ff <= hwrite;
         dph_addr_ff  <= haddr[7:0];
      end
   end

   assign csr_wr    = dph_valid_ff & dph_write_ff & (dph_addr_ff == OFS_CSR);
   assign clk_wr    = dph_valid_ff & dph_write_ff
                      & (dph_addr_ff == OFS_CLK_SEL);
   assign result_rd = dph_valid_ff & ~dph_write_ff
                      & (dph_addr_ff == OFS_RESULT);

   always_comb
   begin
      hrdata = 32'h0000_0000;
      if (dph_valid_ff && !dph_write_ff)
      begin
         if (dph_addr_ff == OFS_CSR)
         begin
            hrdata[7:0] = control_status_reg_ff;
            // done reads 0 while irq enabled
            hrdata[CSR_DONE_BIT] = control_status_reg_ff.done
                                   & ~control_status_reg_ff.irq_en;
         end
         else if (dph_addr_ff == OFS_RESULT)
         begin
            hrdata[7:0] = conversion_result_ff;
         end
         else if (dph_addr_ff == OFS_CLK_SEL)
         begin
            hrdata[7:0] = clock_select_reg_ff;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         control_status_reg_ff <= csr_s'(CSR_RESET);
      end
      else
      begin
         if (csr_wr)
         begin
            control_status_reg_ff.irq_en <= hwdata[CSR_IRQ_BIT];
            control_status_reg_ff.cont   <= hwdata[CSR_CONT_BIT];
            control_status_reg_ff.chan   <= hwdata[4:0];
         end
         // done set at end unless irq enabled, result read clears
         if (conv_done && !control_status_reg_ff.irq_en)
         begin
            control_status_reg_ff.done <= 1'b1;
         end
         else if (result_rd)
         begin
            control_status_reg_ff.done <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         clock_select_reg_ff <= clk_sel_s'(CLK_SEL_RESET);
      end
      else if (clk_wr)
      begin
         clock_select_reg_ff.prescale <= hwdata[7:5];
         clock_select_reg_ff.src_bus  <= hwdata[4];
         clock_select_reg_ff.unused   <= 4'h0;
      end
   end

   // irq set at end, cleared by result read or csr write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         irq_ff <= 1'b0;
      end
      else if (conv_done && control_status_reg_ff.irq_en)
      begin
         irq_ff <= 1'b1;
      end
      else if (result_rd || csr_wr)
      begin
         irq_ff <= 1'b0;
      end
   end

   assign done_irq = irq_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         conversion_result_ff <= 8'h00;
      end
      else if (conv_done)
      begin
         conversion_result_ff <= sar_final;
      end
   end

   // synchronise crystal clock, comparator and pins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         xtal_meta_ff <= 1'b0;
         xtal_sync_ff <= 1'b0;
         xtal_prev_ff <= 1'b0;
         comp_meta_ff <= 1'b0;
         comp_sync_ff <= 1'b0;
         pin_meta_ff  <= '0;
         pin_sync_ff  <= '0;
      end
      else
      begin
         xtal_meta_ff <= crystal_clock;
         xtal_sync_ff <= xtal_meta_ff;
         xtal_prev_ff <= xtal_sync_ff;
         comp_meta_ff <= comparator_in;
         comp_sync_ff <= comp_meta_ff;
         pin_meta_ff  <= pin_in;
         pin_sync_ff  <= pin_meta_ff;
      end
   end

   assign src_tick = clock_select_reg_ff.src_bus
                     | (xtal_sync_ff & ~xtal_prev_ff);

   always_comb
   begin
      div_last = 4'hF;
      if (!clock_select_reg_ff.prescale[2])
      begin
         case (clock_select_reg_ff.prescale[1:0])
            2'h0:    div_last = 4'h0;
            2'h1:    div_last = 4'h1;
            2'h2:    div_last = 4'h3;
            default: div_last = 4'h7;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_cnt_ff <= 4'h0;
      end
      else if (src_tick)
      begin
         div_cnt_ff <= (div_cnt_ff >= div_last) ? 4'h0 : div_cnt_ff + 4'h1;
      end
   end

   assign adc_tick = src_tick & (div_cnt_ff >= div_last);

   // all ones turns the converter off
   assign powered = (control_status_reg_ff.chan != CHAN_OFF);

   // trial bit at bit_idx_ff resolved from the comparator
   always_comb
   begin
      sar_final = sar_ff;
      if (!comp_sync_ff)
      begin
         sar_final[bit_idx_ff] = 1'b0;
      end
   end

   assign conv_done = (state_ff == ST_CONVERT) & adc_tick & ~stop_mode
                      & (bit_idx_ff == 3'h0);

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         start_pend_ff <= 1'b0;
      end
      // a csr write starts a conversion unless it selects the all-ones off code
      else if (csr_wr)
      begin
         start_pend_ff <= (hwdata[4:0] != CHAN_OFF);
      end
      else if (stop_mode && state_ff != ST_IDLE)
      begin
         start_pend_ff <= 1'b1;
      end
      else if (!powered || (state_ff == ST_IDLE && adc_tick && !stop_mode))
      begin
         start_pend_ff <= 1'b0;
      end
   end

   // conversion sequencer
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_ff    <= ST_IDLE;
         samp_cnt_ff <= 3'h0;
         bit_idx_ff  <= MSB_INDEX;
         sar_ff      <= 8'h00;
      end
      // stop aborts; a csr write restarts
      else if (stop_mode || csr_wr || !powered)
      begin
         state_ff    <= ST_IDLE;
         samp_cnt_ff <= 3'h0;
         bit_idx_ff  <= MSB_INDEX;
      end
      else if (adc_tick)
      begin
         case (state_ff)
            ST_IDLE:
            begin
               if (start_pend_ff)
               begin
                  state_ff    <= ST_SAMPLE;
                  samp_cnt_ff <= 3'h0;
               end
            end
            ST_SAMPLE:
            begin
               samp_cnt_ff <= samp_cnt_ff + 3'h1;
               if (samp_cnt_ff == SAMPLE_LAST)
               begin
                  state_ff   <= ST_CONVERT;
                  bit_idx_ff <= MSB_INDEX;
                  sar_ff     <= SAR_FIRST;
               end
            end
            ST_CONVERT:
            begin
               // msb first, one bit per tick
               if (bit_idx_ff == 3'h0)
               begin
                  sar_ff <= sar_final;
                  if (control_status_reg_ff.cont)
                  begin
                     state_ff    <= ST_SAMPLE;
                     samp_cnt_ff <= 3'h0;
                  end
                  else
                  begin
                     state_ff <= ST_IDLE;
                  end
               end
               else
               begin
                  sar_ff                   <= sar_final;
                  sar_ff[bit_idx_ff - 3'h1] <= 1'b1;
                  bit_idx_ff               <= bit_idx_ff - 3'h1;
               end
            end
            default:
            begin
               state_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // code tracks the trial dac against the reference span
   assign dac_code        = sar_ff;
   // channel code passed to the analog mux
   assign analog_mux_sel  = control_status_reg_ff.chan;
   assign analog_power_on = powered;
   assign sample_en       = (state_ff == ST_SAMPLE);

   // shared port pins
   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++)
      begin : g_pin
         logic sel;
         // codes 0 to 7 pick a pin
         assign sel = (control_status_reg_ff.chan == 5'(gi));
         // selected pin forced to analog input
         assign analog_switch_en[gi] = sel;
         // port writes ignored, read returns 0
         assign pin_oe[gi]    = port_dir[gi] & ~sel;
         assign pin_out[gi]   = port_data[gi] & ~sel;
         assign port_read[gi] = pin_sync_ff[gi] & ~sel;
      end
   endgenerate

endmodule

`default_nettype wire

// ===== tb/adc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker
   import adc_ctrl_pkg::*;
#(
   parameter int unsigned NUM_PINS = 8
)
(
   // bus
   input wire logic                hclk,
   input wire logic                hresetn,
   input wire logic                hsel,
   input wire logic [31:0]         haddr,
   input wire logic [1:0]          htrans,
   input wire logic                hwrite,
   input wire logic                hready,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [31:0]         hrdata,
   // converter and pins
   input wire logic                stop_mode,
   input wire logic [4:0]          analog_mux_sel,
   input wire logic                analog_power_on,
   input wire logic [NUM_PINS-1:0] port_data,
   input wire logic [NUM_PINS-1:0] port_dir,
   input wire logic [NUM_PINS-1:0] pin_out,
   input wire logic [NUM_PINS-1:0] pin_oe,
   input wire logic [NUM_PINS-1:0] port_read,
   input wire logic [NUM_PINS-1:0] analog_switch_en,
   input wire logic                done_irq
);
   logic take;
   logic wcsr_ff;
   logic rres_ff;
   logic rd_ff;
   assign take = hsel && hready && htrans[1];
   // data phase markers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wcsr_ff <= 1'b0;
         rres_ff <= 1'b0;
         rd_ff   <= 1'b0;
      end
      else
      begin
         wcsr_ff <= take && hwrite && haddr[7:0] == OFS_CSR;
         rres_ff <= take && !hwrite && haddr[7:0] == OFS_RESULT;
         rd_ff   <= take && !hwrite;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave stalled or errored");
   chk_sel_analog: assert property (
      analog_mux_sel <= CHAN_LAST_PIN && $stable(analog_mux_sel)
      && $stable(analog_switch_en) |-> !pin_oe[analog_mux_sel[2:0]]
      && analog_switch_en == NUM_PINS'(1) << analog_mux_sel[2:0])
      else $error("selected pin not taken over");
   chk_sel_read_zero: assert property (
      analog_switch_en != '0 |-> (port_read & analog_switch_en) == '0)
      else $error("selected pin reads nonzero");
   chk_unsel_port: assert property (
      (pin_oe | analog_switch_en) == (port_dir | analog_switch_en)
      && (pin_out | analog_switch_en) == (port_data | analog_switch_en))
      else $error("unselected pin left port control");
   chk_power_off: assert property (
      $stable(analog_mux_sel) && $stable(analog_power_on)
      |-> analog_power_on == (analog_mux_sel != CHAN_OFF))
      else $error("power state wrong");
   chk_ref_no_pin: assert property (
      analog_mux_sel > CHAN_LAST_PIN && $stable(analog_mux_sel)
      && $stable(analog_switch_en) |-> analog_switch_en == '0)
      else $error("pin switched for internal channel");
   chk_irq_read_clr: assert property (rres_ff |=> !done_irq)
      else $error("irq kept after result read");
   chk_irq_write_clr: assert property (wcsr_ff |=> !done_irq)
      else $error("irq kept after csr write");
   chk_stop_quiet: assert property (
      stop_mode [*4] |-> !$rose(done_irq))
      else $error("completion during stop");
   chk_rdata_idle: assert property (
      hrdata[31:8] == 24'h000000 && (rd_ff || hrdata == 32'h0))
      else $error("read data outside data phase");
endmodule
bind adc_ctrl adc_ctrl_checker #(.NUM_PINS(NUM_PINS)) chk (.hclk,
   .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout, .hresp,
   .hrdata, .stop_mode, .analog_mux_sel, .analog_power_on, .port_data,
   .port_dir, .pin_out, .pin_oe, .port_read, .analog_switch_en, .done_irq);
`default_nettype wire

// ===== tb/adc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model
   import adc_ctrl_pkg::*;
(
   // converter side
   input  wire logic [7:0] dac_code,
   input  wire logic [4:0] analog_mux_sel,
   input  wire logic       analog_power_on,
   input  wire logic       slow,
   input  wire logic [7:0] level [8],
   output logic            comparator_in,
   // pads
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pad,
   output logic [7:0]      pin_in
);
   logic [7:0] vin;
   always_comb
      case (analog_mux_sel)
         CHAN_UPPER: vin = 8'hFF;
         CHAN_LOWER: vin = 8'h00;
         default:    vin = level[analog_mux_sel[2:0]];
      endcase
   // settles after a lag, wanders while unpowered
   always @(dac_code, vin, analog_power_on, slow)
      comparator_in <= #(slow ? 40 : 2)
         analog_power_on ? vin >= dac_code : comparator_in !== 1'b1;
   // a driven pad reads back its own level
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad);
endmodule
`default_nettype wire

// ===== tb/eight_channel_adc_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eight_channel_adc_control_tb;
   import adc_ctrl_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, crystal_clock, stop_mode;
   logic        hreadyout, hresp, comparator_in, analog_power_on;
   logic        sample_en, done_irq, slow, ok;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [4:0]  analog_mux_sel, c;
   logic [7:0]  dac_code, port_data, port_dir, pad, pin_in, pin_out, e;
   logic [7:0]  pin_oe, port_read, analog_switch_en, level [8];
   logic [31:0] haddr, hwdata, hrdata, rd;
   int          fail_count, num_checks, seed, n, cyc, r, samp;

   adc_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .crystal_clock, .stop_mode, .comparator_in, .dac_code, .analog_mux_sel,
      .analog_power_on, .sample_en, .port_data, .port_dir, .pin_in, .pin_out,
      .pin_oe, .port_read, .analog_switch_en, .done_irq);
   adc_analog_model far (.dac_code, .analog_mux_sel, .analog_power_on, .slow,
      .level, .comparator_in, .pin_out, .pin_oe, .pad, .pin_in);

   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   always @(posedge hclk)
      crystal_clock <= (crystal_clock !== 1'b1);

   task automatic check(input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic timeout;
      fail_count++;
      print_verdict;
   endtask
   // one bus phase, held until hready is seen high
   task automatic ready;
      n = 0;
      do
      begin
         @(negedge hclk);
         rd = hrdata;
         ok = hreadyout;
         n++;
         @(posedge hclk);
      end
      while (ok !== 1'b1 && n < 50);
      if (n >= 50)
         timeout;
   endtask
   // done position always written as 0
   task automatic bus(input logic wr, input logic [7:0] a, d);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr  <= {24'h000000, a};
      ready;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      ready;
   endtask
   task automatic wait_irq;
      cyc = 0;
      samp = 0;
      do
      begin
         @(negedge hclk);
         cyc++;
         if (sample_en === 1'b1)
            samp++;
      end
      while (done_irq !== 1'b1 && cyc < 2000);
      @(posedge hclk);
      if (cyc >= 2000)
         timeout;
   endtask
   task automatic poll_done;
      r = 0;
      do
      begin
         bus(1'b0, OFS_CSR, 8'h00);
         r++;
      end
      while (rd[7] !== 1'b1 && r < 400);
      if (r >= 400)
         timeout;
   endtask
   task automatic look(input logic [31:0] exp);
      @(negedge hclk);
      check(done_irq, exp);
      @(posedge hclk);
   endtask
   function automatic logic [7:0] exp_code(input logic [4:0] ch);
      if (ch == CHAN_UPPER)
         return 8'hFF;
      if (ch == CHAN_LOWER)
         return 8'h00;
      return level[ch[2:0]];
   endfunction

   initial
   begin
      seed = 16562;
      {hresetn, hsel, hwrite, stop_mode, slow} = '0;
      {haddr, hwdata, port_data, port_dir, pad} = '0;
      htrans = 2'b00;
      hsize = 3'b010;
      foreach (level[i])
         level[i] = 8'($random(seed));
      fail_count = 0;
      num_checks = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, OFS_CSR, 8'h00);
      check(rd, 32'h1F);
      bus(1'b0, OFS_CLK_SEL, 8'h00);
      check(rd, {24'h000000, CLK_SEL_RESET});
      bus(1'b1, 8'h50, 8'hFF);
      bus(1'b0, 8'h50, 8'h00);
      check(rd, 32'h0);
      // crystal source ticks every second bus clock
      bus(1'b1, OFS_CSR, 8'h40);
      wait_irq;
      check(cyc >= 28 && cyc <= 44, 1'b1);
      check(samp, 32'h10);
      bus(1'b0, OFS_RESULT, 8'h00);
      for (int k = 0; k < 8; k++)
      begin
         bus(1'b1, OFS_CLK_SEL, {k[2:0], 5'h10});
         bus(1'b1, OFS_CSR, 8'h40);
         wait_irq;
         r = k > 3 ? 16 : 1 << k;
         check(cyc >= 15 * r && cyc <= 17 * r + 6, 1'b1);
         check(samp, 8 * r);
         bus(1'b0, OFS_CSR, 8'h00);
         check(rd, 32'h40);
         bus(1'b0, OFS_RESULT, 8'h00);
         if (k > 2)
            check(rd, {24'h000000, level[0]});
      end
      for (int k = 0; k < 10; k++)
      begin
         c = k < 8 ? 5'(k) : 5'(k + 21);
         level[k % 8] = 8'($random(seed));
         {port_data, port_dir, pad} <= 24'($random(seed));
         slow <= k[0];
         bus(1'b1, OFS_CSR, {3'b000, c});
         poll_done;
         check(rd, {24'h000000, 3'b100, c});
         bus(1'b0, OFS_RESULT, 8'h00);
         check(rd, {24'h000000, exp_code(c)});
         bus(1'b0, OFS_CSR, 8'h00);
         check(rd, {27'h0, c});
         e = ((port_dir & port_data) | (~port_dir & pad))
            & ~(c < 5'h08 ? 8'h01 << c : 8'h00);
         @(negedge hclk);
         check(port_read, e);
         @(posedge hclk);
      end
      bus(1'b1, OFS_CSR, 8'h22);
      for (int k = 0; k < 3; k++)
      begin
         level[2] = 8'($random(seed));
         repeat (700) @(posedge hclk);
         bus(1'b0, OFS_RESULT, 8'h00);
         check(rd, {24'h000000, level[2]});
      end
      bus(1'b1, OFS_CSR, 8'h02);
      // result of the interrupted conversion is discarded
      bus(1'b0, OFS_RESULT, 8'h00);
      poll_done;
      bus(1'b0, OFS_RESULT, 8'h00);
      check(rd, {24'h000000, level[2]});
      repeat (700) @(posedge hclk);
      bus(1'b0, OFS_CSR, 8'h00);
      check(rd, 32'h02);
      bus(1'b1, OFS_CSR, 8'h43);
      repeat (100) @(posedge hclk);
      stop_mode <= 1'b1;
      repeat (600) @(posedge hclk);
      look(32'h0);
      stop_mode <= 1'b0;
      wait_irq;
      bus(1'b1, OFS_CSR, 8'h03);
      look(32'h0);
      poll_done;
      bus(1'b0, OFS_RESULT, 8'h00);
      check(rd, {24'h000000, level[3]});
      bus(1'b1, OFS_CSR, 8'h1F);
      repeat (700) @(posedge hclk);
      bus(1'b0, OFS_CSR, 8'h00);
      check(rd, 32'h1F);
      print_verdict;
   end
endmodule
`default_nettype wire
